/* File: rtl/mmd_decoder.sv */
`timescale 1ns/1ns
`include "mmd_consts.svh"
module mmd_decoder #(
   parameter int FLASH_WORDS = `MMD_FLASH_WORDS,
   parameter int SRAM_WORDS  = `MMD_SRAM_WORDS
) (
   input  wire logic        sys_clk_in,
   input  wire logic        nrst_in,
   input  wire logic        req_in,
   input  wire logic        wr_in,
   input  wire logic [1:0]  size_in,
   input  wire logic [31:0] addr_in,
   input  wire logic [31:0] wdata_in,
   input  wire logic [15:0] flash_rdata_in,
   input  wire logic [31:0] sram_rdata_in,
   input  wire logic [31:0] fast_rdata_in,
   input  wire logic [31:0] slow_rdata_in,
   input  wire logic        slow_hit_in,
   output logic             ready_out,
   output logic [31:0]      rdata_out,
   output logic             remap_sram_out,
   output logic             flash_rd_out,
   output logic [14:0]      flash_addr_out,
   output logic             flash_boot_out,
   output logic [7:0]       flash_page_out,
   output logic             sram_en_out,
   output logic             sram_wr_out,
   output logic [10:0]      sram_addr_out,
   output logic [3:0]       sram_ben_out,
   output logic [31:0]      wdata_out,
   output logic             fast_en_out,
   output logic             slow_en_out,
   output logic             per_wr_out,
   output logic [31:0]      per_addr_out,
   output logic [3:0]       per_ben_out
);
   localparam int FAW = $clog2(FLASH_WORDS);
   localparam int SAW = $clog2(SRAM_WORDS);

   typedef enum logic [1:0] {MMD_IDLE, MMD_FL_HI, MMD_SLOW2, MMD_DONE}
      mmd_st_e;

   typedef struct packed {
      mmd_st_e     st;
      logic        remap;
      logic        rdy;
      logic [31:0] rdata;
      logic [15:0] fl_lo;
      logic [31:0] addr;
      logic        wr;
      logic [1:0]  size;
      logic        fl_rd;
      logic [14:0] fl_addr;
      logic        sr_en;
      logic        sr_wr;
      logic [3:0]  ben;
      logic [31:0] wdata;
      logic        fast;
      logic        slow;
      logic        sram0;
      logic        boot;
   } mmd_state_s;

   mmd_state_s cur;
   mmd_state_s next_cur;
   mmd_pkg::mmd_tgt_e tgt;
   logic [31:0]       fl_word;
   logic              take;

   mmd_lane_if lane ();
   mmd_lane_align u_align (
      .lane (lane)
   );

   // ------------------------------------------------------------
   // Address window decode
   // ------------------------------------------------------------
   // Page 0 follows the remap bit; upper pages are the real homes
   function automatic mmd_pkg::mmd_tgt_e decode(input logic [31:0] a,
                                                 input logic remap);
      logic [15:0] pg;
      pg = a[31:`MMD_WIN_SHIFT];
      if (a == `MMD_REMAP_ADDR)
         return mmd_pkg::MMD_T_REMAP;
      if (pg == 16'h0000)
         return remap ? mmd_pkg::MMD_T_FLASH
                      : mmd_pkg::MMD_T_SRAM;
      if (pg == 16'(`MMD_FLASH_BASE >> `MMD_WIN_SHIFT))
         return mmd_pkg::MMD_T_FLASH;
      if (pg == 16'(`MMD_SRAM_BASE >> `MMD_WIN_SHIFT))
         return mmd_pkg::MMD_T_SRAM;
      if (pg[15:1] == 15'h7FFF) begin
         if (a >= `MMD_FAST_LO && a < `MMD_FAST_HI)
            return mmd_pkg::MMD_T_FAST;
         return mmd_pkg::MMD_T_SLOW;
      end
      return mmd_pkg::MMD_T_NONE;
   endfunction

   assign tgt = decode(addr_in, cur.remap);

   // A held request in the ready cycle is the old one, not a new one
   assign take = req_in && cur.st == MMD_IDLE && !cur.rdy;

   // Flash halfwords joined little-endian, low half first; a narrow
   // read fetched one halfword, which then sits in both lanes
   assign fl_word = (cur.size == 2'h2) ? {flash_rdata_in, cur.fl_lo}
                                       : {2{cur.fl_lo}};

   assign lane.size    = (cur.st == MMD_IDLE) ? size_in : cur.size;
   assign lane.lsb     = (cur.st == MMD_IDLE) ? addr_in[1:0] : cur.addr[1:0];
   assign lane.wdata   = wdata_in;
   assign lane.word_in = fl_word;

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      next_cur       = cur;
      next_cur.rdy   = 1'b0;
      next_cur.fl_rd = 1'b0;
      next_cur.sr_en = 1'b0;
      next_cur.sr_wr = 1'b0;
      next_cur.fast  = 1'b0;
      next_cur.slow  = 1'b0;
      unique case (cur.st)
         MMD_IDLE: begin
            if (take) begin
               next_cur.addr  = addr_in;
               next_cur.wr    = wr_in;
               next_cur.size  = size_in;
               // Lanes steered once here, so the write data is a flop
               next_cur.wdata = lane.wlane;
               next_cur.ben   = lane.ben;
               unique case (tgt)
                  mmd_pkg::MMD_T_FLASH: begin
                     // Writes go through flash control, not here
                     next_cur.fl_rd   = !wr_in;
                     next_cur.fl_addr = (size_in == 2'h2)
                        ? {addr_in[FAW:2], 1'b0}
                        : addr_in[FAW:1];
                     next_cur.st      = wr_in ? MMD_DONE : MMD_FL_HI;
                  end
                  mmd_pkg::MMD_T_SRAM: begin
                     next_cur.sr_en = 1'b1;
                     next_cur.sr_wr = wr_in;
                     next_cur.st    = MMD_DONE;
                  end
                  mmd_pkg::MMD_T_FAST: begin
                     next_cur.fast = 1'b1;
                     next_cur.st   = MMD_DONE;
                  end
                  mmd_pkg::MMD_T_SLOW: begin
                     next_cur.slow = 1'b1;
                     next_cur.st   = MMD_SLOW2;
                  end
                  mmd_pkg::MMD_T_REMAP: begin
                     if (wr_in)
                        next_cur.remap = wdata_in[`MMD_REMAP_BIT];
                     next_cur.rdata = {31'h0000_0000, cur.remap};
                     next_cur.rdy   = 1'b1;
                  end
                  default: begin
                     next_cur.rdata = `MMD_ZERO32;
                     next_cur.rdy   = 1'b1;
                  end
               endcase
            end
         end
         MMD_FL_HI: begin
            // Second 16-bit read in the very next cycle
            next_cur.fl_lo = flash_rdata_in;
            if (cur.size == 2'h2) begin
               next_cur.fl_rd   = 1'b1;
               next_cur.fl_addr = cur.fl_addr + 15'h0001;
            end
            next_cur.st = MMD_DONE;
         end
         MMD_SLOW2: begin
            next_cur.slow = 1'b1;
            next_cur.st   = MMD_DONE;
         end
         MMD_DONE: begin
            next_cur.rdy = 1'b1;
            next_cur.st  = MMD_IDLE;
            if (cur.wr)
               next_cur.rdata = `MMD_ZERO32;
            else
               // Flash reads steered by size and low address bits
               next_cur.rdata = lane.rdata;
            if (cur.sr_en)
               next_cur.rdata = cur.wr ? `MMD_ZERO32 : sram_rdata_in;
            if (cur.fast)
               next_cur.rdata = fast_rdata_in;
            if (cur.slow)
               // Empty slow slots read zero, no stall
               next_cur.rdata = slow_hit_in ? slow_rdata_in
                                            : `MMD_ZERO32;
         end
      endcase
      // Synchronous reset wins over any request in the same cycle
      if (!nrst_in) begin
         next_cur       = '0;
         next_cur.st    = MMD_IDLE;
         next_cur.remap = `MMD_REMAP_RST;
      end
      // Registered copies so those outputs come straight from flops
      next_cur.sram0 = !next_cur.remap;
      next_cur.boot  = next_cur.fl_addr >= 15'(`MMD_FLASH_USER);
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   // Reset is folded into next_cur above
   always_ff @(posedge sys_clk_in) begin
      cur <= next_cur;
   end

   // ------------------------------------------------------------
   // Outputs straight from state
   // ------------------------------------------------------------
   assign ready_out      = cur.rdy;
   assign rdata_out      = cur.rdata;
   assign remap_sram_out = cur.sram0;
   assign flash_rd_out   = cur.fl_rd;
   assign flash_addr_out = cur.fl_addr;
   // Boot kernel lives in the top 1k words
   assign flash_boot_out = cur.boot;
   assign flash_page_out = {1'b0, cur.addr[15:`MMD_PAGE_SHIFT]};
   assign sram_en_out    = cur.sr_en;
   assign sram_wr_out    = cur.sr_wr;
   assign sram_addr_out  = cur.addr[SAW+1:2];
   assign sram_ben_out   = cur.ben;
   assign wdata_out      = cur.wdata;
   assign fast_en_out    = cur.fast;
   assign slow_en_out    = cur.slow;
   assign per_wr_out     = cur.wr;
   assign per_addr_out   = cur.addr;
   assign per_ben_out    = cur.ben;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   sequence s_slow_req;
      take && tgt == mmd_pkg::MMD_T_SLOW;
   endsequence

   a_reset_remap: assert property (@(posedge sys_clk_in)
      !nrst_in |=> cur.remap)
      else $error("remap not set after reset");
   a_remap_clear: assert property (@(posedge sys_clk_in)
      disable iff (!nrst_in)
      take && wr_in
      && addr_in == `MMD_REMAP_ADDR && !wdata_in[0] |=> remap_sram_out)
      else $error("remap clear ignored");
   a_slow_two: assert property (@(posedge sys_clk_in)
      disable iff (!nrst_in)
      s_slow_req |=> slow_en_out ##1 slow_en_out ##1 ready_out)
      else $error("slow access not two cycles");
   a_fast_one: assert property (@(posedge sys_clk_in)
      disable iff (!nrst_in)
      take && tgt == mmd_pkg::MMD_T_FAST
      |=> fast_en_out ##1 ready_out)
      else $error("fast access not one cycle");
   a_flash_pair: assert property (@(posedge sys_clk_in)
      disable iff (!nrst_in)
      take && !wr_in && size_in == 2'h2
      && tgt == mmd_pkg::MMD_T_FLASH
      |=> flash_rd_out ##1 flash_rd_out ##1 ready_out)
      else $error("word fetch not two flash reads");
   a_empty_zero: assert property (@(posedge sys_clk_in)
      disable iff (!nrst_in)
      take && tgt == mmd_pkg::MMD_T_NONE
      |=> ready_out && rdata_out == 32'h0000_0000)
      else $error("unmapped read not zero");
   a_sram_single: assert property (@(posedge sys_clk_in)
      disable iff (!nrst_in)
      take && tgt == mmd_pkg::MMD_T_SRAM
      |=> sram_en_out ##1 ready_out)
      else $error("sram not single access");
   a_zero_page: assert property (@(posedge sys_clk_in)
      disable iff (!nrst_in)
      take && !wr_in && cur.remap && addr_in[31:16] == 16'h0000
      |=> flash_rd_out)
      else $error("page zero not flash");
   a_byte_lane: assert property (@(posedge sys_clk_in)
      disable iff (!nrst_in)
      sram_en_out && cur.size == 2'h0
      |-> sram_ben_out == (4'h1 << cur.addr[1:0]))
      else $error("byte lane wrong");
endmodule

/* File: rtl/mmd_consts.svh */
`ifndef MMD_CONSTS_SVH
`define MMD_CONSTS_SVH
// Address windows
`define MMD_FLASH_BASE   32'h0008_0000
`define MMD_SRAM_BASE    32'h0001_0000
`define MMD_MMR_BASE     32'hFFFF_0000
`define MMD_WIN_SHIFT    16
`define MMD_MMR_SHIFT    16
// Flash geometry in 16-bit words, page size in bytes; SRAM size in 32-bit words
`define MMD_FLASH_WORDS  32768
`define MMD_FLASH_USER   31744
`define MMD_PAGE_BYTES   512
`define MMD_PAGE_SHIFT   9
`define MMD_SRAM_WORDS   2048
// Remap register
`define MMD_REMAP_ADDR   32'hFFFF_0220
`define MMD_REMAP_BIT    0
`define MMD_REMAP_RST    1'b1
// Fast bus register window (flash control and GPIO)
`define MMD_FAST_LO      32'hFFFF_F400
`define MMD_FAST_HI      32'hFFFF_F820
// Cycle costs and the all-zero read word
`define MMD_APB_WAIT     2'h1
`define MMD_ZERO32       32'h0000_0000
`endif

/* File: rtl/mmd_pkg.sv */
package mmd_pkg;
   typedef enum logic [1:0] {MMD_SZ8, MMD_SZ16, MMD_SZ32} mmd_size_e;
   typedef enum logic [2:0] {
      MMD_T_FLASH, MMD_T_SRAM, MMD_T_FAST, MMD_T_SLOW, MMD_T_REMAP,
      MMD_T_NONE
   } mmd_tgt_e;
endpackage

/* File: rtl/mmd_lane_if.sv */
`timescale 1ns/1ns
// Byte lane carrier between decoder and lane aligner
interface mmd_lane_if;
   logic [1:0]  size;
   logic [1:0]  lsb;
   logic [31:0] wdata;
   logic [31:0] word_in;
   logic [31:0] wlane;
   logic [3:0]  ben;
   logic [31:0] rdata;
   modport core  (output size, lsb, wdata, word_in,
                  input wlane, ben, rdata);
   modport align (input size, lsb, wdata, word_in,
                  output wlane, ben, rdata);
endinterface

/* File: rtl/mmd_lane_align.sv */
`timescale 1ns/1ns
// Little-endian lane steering: byte n of a word sits at address n
module mmd_lane_align (
   mmd_lane_if.align lane
);
   // ------------------------------------------------------------
   // Write replication and read extraction
   // ------------------------------------------------------------
   always_comb begin
      lane.wlane = 32'h0000_0000;
      lane.ben   = 4'h0;
      lane.rdata = 32'h0000_0000;
      unique case (lane.size)
         2'h0: begin
            lane.wlane = {4{lane.wdata[7:0]}};
            lane.ben   = 4'h1 << lane.lsb;
            lane.rdata = {24'h00_0000,
               lane.word_in[{lane.lsb, 3'h0} +: 8]};
         end
         2'h1: begin
            lane.wlane = {2{lane.wdata[15:0]}};
            lane.ben   = lane.lsb[1] ? 4'hC : 4'h3;
            lane.rdata = {16'h0000,
               lane.word_in[{lane.lsb[1], 4'h0} +: 16]};
         end
         default: begin
            lane.wlane = lane.wdata;
            lane.ben   = 4'hF;
            lane.rdata = lane.word_in;
         end
      endcase
   end
endmodule

/* File: verification/mmd_mem_model.sv */
`timescale 1ns/1ns
// -----------------------------------------------------------
// Flash, SRAM and register stand-ins behind the decoder
// -----------------------------------------------------------
module mmd_mem_model (
   input  wire logic        clk_in,
   input  wire logic        flash_rd_in,
   input  wire logic [14:0] flash_addr_in,
   input  wire logic        sram_en_in,
   input  wire logic        sram_wr_in,
   input  wire logic [10:0] sram_addr_in,
   input  wire logic [3:0]  sram_ben_in,
   input  wire logic [31:0] wr_data_in,
   input  wire logic        fast_en_in,
   input  wire logic        slow_en_in,
   input  wire logic [31:0] per_addr_in,
   output logic [15:0]      flash_rdata_out,
   output logic [31:0]      sram_rdata_out,
   output logic [31:0]      fast_rdata_out,
   output logic [31:0]      slow_rdata_out,
   output logic             slow_hit_out
);
   logic [31:0] mem [0:2047];
   logic [31:0] sram_hold;
   logic [31:0] per_hold;
   logic [15:0] fl_last;
   // Halfword in the strobe's own cycle; inverse of the last when idle
   always_ff @(posedge clk_in) begin
      if (flash_rd_in) begin
         fl_last <= {1'b1, flash_addr_in};
      end
   end
   assign flash_rdata_out = flash_rd_in ? {1'b1, flash_addr_in} : ~fl_last;
   // Byte-enabled SRAM; last read held so late sampling works
   always_ff @(posedge clk_in) begin
      if (sram_en_in) begin
         sram_hold <= mem[sram_addr_in];
         for (int i = 0; i < 4; i++) begin
            if (sram_wr_in && sram_ben_in[i]) begin
               mem[sram_addr_in][8*i +: 8] <= wr_data_in[8*i +: 8];
            end
         end
      end
      if (fast_en_in || slow_en_in) begin
         per_hold <= ~per_addr_in;
      end
   end
   // Register data is the inverted address, so routing shows
   assign sram_rdata_out = sram_en_in ? mem[sram_addr_in] : sram_hold;
   assign fast_rdata_out = fast_en_in ? ~per_addr_in : per_hold;
   assign slow_rdata_out = slow_en_in ? ~per_addr_in : per_hold;
   // One unoccupied gap in the slow register area
   assign slow_hit_out = per_addr_in[15:8] != 8'h0C;
endmodule

/* File: verification/tb.sv */
`timescale 1ns/1ns
`include "mmd_consts.svh"
module tb;
   logic        sys_clk_in, nrst_in, req_in, wr_in;
   logic [1:0]  size_in;
   logic [31:0] addr_in, wdata_in, sram_rdata_in, fast_rdata_in;
   logic [31:0] slow_rdata_in, rdata_out, wdata_out, per_addr_out;
   logic [15:0] flash_rdata_in, sv;
   logic [14:0] flash_addr_out;
   logic [10:0] sram_addr_out;
   logic [7:0]  flash_page_out;
   logic [3:0]  sram_ben_out, per_ben_out;
   logic        slow_hit_in, ready_out, remap_sram_out, flash_rd_out;
   logic        flash_boot_out, sram_en_out, sram_wr_out, fast_en_out;
   logic        slow_en_out, per_wr_out;
   logic [23:0] frq[$];
   logic [4:0]  pw;
   int          mismatches, cmp_count, n_fast, n_slow, cyc;

   mmd_decoder u_mmd_decoder (.sys_clk_in, .nrst_in, .req_in, .wr_in,
      .size_in, .addr_in, .wdata_in, .flash_rdata_in, .sram_rdata_in,
      .fast_rdata_in, .slow_rdata_in, .slow_hit_in, .ready_out,
      .rdata_out, .remap_sram_out, .flash_rd_out, .flash_addr_out,
      .flash_boot_out, .flash_page_out, .sram_en_out, .sram_wr_out,
      .sram_addr_out, .sram_ben_out, .wdata_out, .fast_en_out,
      .slow_en_out, .per_wr_out, .per_addr_out, .per_ben_out);
   mmd_mem_model u_mmd_mem_model (.clk_in(sys_clk_in),
      .flash_rd_in(flash_rd_out), .flash_addr_in(flash_addr_out),
      .sram_en_in(sram_en_out), .sram_wr_in(sram_wr_out),
      .sram_addr_in(sram_addr_out), .sram_ben_in(sram_ben_out),
      .wr_data_in(wdata_out), .fast_en_in(fast_en_out),
      .slow_en_in(slow_en_out), .per_addr_in(per_addr_out),
      .flash_rdata_out(flash_rdata_in), .sram_rdata_out(sram_rdata_in),
      .fast_rdata_out(fast_rdata_in), .slow_rdata_out(slow_rdata_in),
      .slow_hit_out(slow_hit_in));
   // -----------------------------------------------------------
   // Clock, monitors and reporting
   // -----------------------------------------------------------
   initial begin
      sys_clk_in = 1'b0;
      forever #4 sys_clk_in = ~sys_clk_in;
   end
   // Records strobes; a hang past the ceiling ends the run
   always @(posedge sys_clk_in) begin
      cyc++;
      if (flash_rd_out === 1'b1) begin
         frq.push_back({flash_boot_out, flash_page_out, flash_addr_out});
      end
      if (sram_en_out === 1'b1) begin
         sv = {sram_wr_out, sram_ben_out, sram_addr_out};
      end
      if (fast_en_out === 1'b1) n_fast++;
      if (slow_en_out === 1'b1) n_slow++;
      if (slow_en_out === 1'b1) pw = {per_wr_out, per_ben_out};
      if (cyc > 3000) begin
         mismatches++;
         end_sim();
      end
   end
   task end_sim;
      if (mismatches == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] %s exp %h got %h", nm, e, g);
      end
   endtask
   function automatic logic [15:0] fpat(input logic [14:0] i);
      return {1'b1, i};
   endfunction
   // One bus access; request held until ready is sampled
   task automatic acc(input logic w, input logic [1:0] sz,
      input logic [31:0] a, input logic [31:0] d,
      output logic [31:0] rd, output int lat);
      int k;
      k = 0;
      frq.delete();
      n_fast = 0;
      n_slow = 0;
      req_in <= 1'b1;
      wr_in <= w;
      size_in <= sz;
      addr_in <= a;
      wdata_in <= d;
      do begin
         @(posedge sys_clk_in);
         k++;
      end while (ready_out !== 1'b1 && k < 20);
      rd = rdata_out;
      lat = k - 1;
      chk("ready_seen", 32'h1, {31'h0, ready_out === 1'b1});
      req_in <= 1'b0;
      @(posedge sys_clk_in);
      chk("ready_pulse", 32'h0, {31'h0, ready_out});
   endtask
   // -----------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------
   task automatic fword(input logic [31:0] off);
      logic [31:0] r;
      int          l;
      logic [14:0] n;
      logic [8:0]  bp;
      n = off[15:1];
      bp = {n[14:10] == 5'h1F, 1'b0, off[15:9]};
      acc(1'b0, 2'h2, `MMD_FLASH_BASE + off, 32'h0, r, l);
      chk("fl_word", {fpat(n + 15'h1), fpat(n)}, r);
      chk("fl_lat", 32'h3, 32'(l));
      chk("fl_nrd", 32'h2, 32'(frq.size()));
      chk("fl_rd0", {8'h0, bp, n}, {8'h0, frq[0]});
      chk("fl_rd1", {8'h0, bp, n + 15'h1}, {8'h0, frq[1]});
   endtask
   task automatic t_flash;
      logic [31:0] r;
      int          l;
      chk("remap_rst", 32'h0, {31'h0, remap_sram_out});
      acc(1'b0, 2'h2, 32'h0, 32'h0, r, l);
      chk("zero_word", {fpat(15'h1), fpat(15'h0)}, r);
      fword(32'h0000_01FC);
      fword(32'h0000_0200);
      fword(32'h0000_F7FC);
      fword(32'h0000_F800);
      for (int s = 0; s < 2; s++) begin
         acc(1'b0, 2'(s), `MMD_FLASH_BASE + 32'h2, 32'h0, r, l);
         chk("fl_narrow", s ? 32'h0000_8001 : 32'h0000_0001, r);
         chk("fl_nlat", 32'h3, 32'(l));
         chk("fl_nnrd", 32'h1, 32'(frq.size()));
      end
      acc(1'b1, 2'h2, `MMD_FLASH_BASE, 32'h1234_5678, r, l);
      chk("fl_wlat", 32'h2, 32'(l));
   endtask
   task automatic t_sram;
      logic [31:0] r;
      logic [31:0] b;
      int          l;
      b = `MMD_SRAM_BASE + 32'h0000_1FFC;
      for (int k = 0; k < 4; k++) begin
         acc(1'b1, 2'h0, b + 32'(k), {4{8'(8'h10 + k)}}, r, l);
         chk("sr_wlat", 32'h2, 32'(l));
         chk("sr_ben", {16'h0, 1'b1, 4'(1 << k), 11'h7FF}, {16'h0, sv});
      end
      acc(1'b0, 2'h2, b, 32'h0, r, l);
      chk("sr_le", 32'h1312_1110, r);
      chk("sr_rlat", 32'h2, 32'(l));
      acc(1'b1, 2'h1, b + 32'h2, {2{16'hBEEF}}, r, l);
      chk("sr_hben", {16'h0, 1'b1, 4'hC, 11'h7FF}, {16'h0, sv});
      acc(1'b0, 2'h2, b, 32'h0, r, l);
      chk("sr_half", 32'hBEEF_1110, r);
   endtask
   task automatic t_per;
      logic [31:0] pa [5] = '{32'hFFFF_F400, 32'hFFFF_F81C, 32'hFFFF_0300,
                               32'hFFFF_0900, 32'hFFFF_0F80};
      logic [31:0] r;
      int          l;
      logic        f;
      for (int i = 0; i < 5; i++) begin
         f = pa[i] >= `MMD_FAST_LO && pa[i] < `MMD_FAST_HI;
         acc(1'b0, 2'h2, pa[i], 32'h0, r, l);
         chk("per_data", ~pa[i], r);
         chk("per_lat", f ? 32'h2 : 32'h3, 32'(l));
         chk("per_fast", {31'h0, f}, 32'(n_fast));
         chk("per_slow", f ? 32'h0 : 32'h2, 32'(n_slow));
      end
      acc(1'b1, 2'h2, 32'hFFFF_0500, 32'h0, r, l);
      chk("per_wlat", 32'h3, 32'(l));
      chk("per_wr", 32'h0000_001F, {27'h0, pw});
      acc(1'b0, 2'h2, 32'hFFFF_0C00, 32'h0, r, l);
      chk("gap_data", 32'h0, r);
      chk("gap_nostall", 32'h1, {31'h0, l <= 3});
      acc(1'b0, 2'h2, 32'h4000_0000, 32'h0, r, l);
      chk("unmap_data", 32'h0, r);
      chk("unmap_lat", 32'h1, 32'(l));
   endtask
   task automatic t_remap;
      logic [31:0] r;
      int          l;
      acc(1'b1, 2'h2, `MMD_SRAM_BASE, 32'hA5C3_0F96, r, l);
      acc(1'b1, 2'h0, `MMD_REMAP_ADDR, 32'h0, r, l);
      chk("rm_lat", 32'h1, 32'(l));
      chk("rm_set", 32'h1, {31'h0, remap_sram_out});
      acc(1'b0, 2'h2, 32'h0, 32'h0, r, l);
      chk("rm_sram", 32'hA5C3_0F96, r);
      chk("rm_nrd", 32'h0, 32'(frq.size()));
      acc(1'b1, 2'h0, `MMD_REMAP_ADDR, 32'h0101_0101, r, l);
      chk("rm_clr", 32'h0, {31'h0, remap_sram_out});
      acc(1'b0, 2'h2, `MMD_REMAP_ADDR, 32'h0, r, l);
      chk("rm_read", 32'h1, r);
      acc(1'b1, 2'h0, `MMD_REMAP_ADDR, 32'h0, r, l);
      nrst_in <= 1'b0;
      repeat (5) @(posedge sys_clk_in);
      nrst_in <= 1'b1;
      @(posedge sys_clk_in);
      chk("rm_rst", 32'h0, {31'h0, remap_sram_out});
      acc(1'b0, 2'h2, 32'h0, 32'h0, r, l);
      chk("rm_flash", {fpat(15'h1), fpat(15'h0)}, r);
   endtask
   // Reset for five cycles, then the scenarios in turn
   initial begin
      nrst_in = 1'b0;
      req_in = 1'b0;
      wr_in = 1'b0;
      size_in = 2'h0;
      addr_in = 32'h0;
      wdata_in = 32'h0;
      repeat (5) @(posedge sys_clk_in);
      nrst_in <= 1'b1;
      @(posedge sys_clk_in);
      t_flash();
      t_sram();
      t_per();
      t_remap();
      end_sim();
   end
endmodule
